/* atp_chk_assertions.sv */
// port assertions of the timer clocking block
`timescale 1ns/1ps
`include "atp_consts.svh"
module atp_chk (
  input wire logic              mclk,
  input wire logic              rst,
  input wire atp_pkg::atp_bus_s bus,
  input wire logic [7:0]        rdata,
  input wire logic              osc_input_pin,
  input wire logic              sleeping,
  input wire logic              deep_sleep,
  input wire logic              osc_run,
  input wire logic              osc_pins_detach,
  input wire logic              cmp_a_out,
  input wire logic              cmp_a_oe,
  input wire logic              cmp_b_out,
  input wire logic              cmp_b_oe,
  input wire logic              wake_req,
  input wire logic              cpu_halt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ctrl_rsvd_zero: assert property ($past(bus.rd) && $past(bus.addr) == `ATP_OFS_CTRL_A
    |-> rdata[3:2] == 2'h0) else $error("reserved bits read nonzero");
  a_status_sel: assert property ($past(bus.rd) && $past(bus.addr) == `ATP_OFS_STATUS
    |-> rdata[5] == $past(osc_pins_detach)) else $error("select bit mismatch");
  a_osc_follow: assert property (osc_run == (osc_pins_detach && !deep_sleep))
    else $error("oscillator enable wrong");
  a_wake_pulse: assert property (wake_req |=> !wake_req) else $error("wake not a pulse");
  a_wake_cause: assert property (wake_req |-> $past(sleeping))
    else $error("wake while awake");
  a_halt_len: assert property ($rose(cpu_halt) |-> cpu_halt[*4] ##1 !cpu_halt)
    else $error("halt length wrong");
  a_halt_cause: assert property ($rose(cpu_halt) |-> wake_req || $past(wake_req))
    else $error("halt without wake");
  a_pin_a_quiet: assert property (!$past(cmp_a_oe) |-> $stable(cmp_a_out))
    else $error("pin a moved while off");
  a_pin_b_quiet: assert property (!$past(cmp_b_oe) |-> $stable(cmp_b_out))
    else $error("pin b moved while off");
  c_wake: cover property (wake_req);
  c_halt: cover property ($rose(cpu_halt));
  c_toggle: cover property ($changed(cmp_a_out));
endmodule : atp_chk
bind atp_timer_clocking atp_chk u_chk (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
  .osc_input_pin(osc_input_pin), .sleeping(sleeping), .deep_sleep(deep_sleep),
  .osc_run(osc_run), .osc_pins_detach(osc_pins_detach), .cmp_a_out(cmp_a_out),
  .cmp_a_oe(cmp_a_oe), .cmp_b_out(cmp_b_out), .cmp_b_oe(cmp_b_oe), .wake_req(wake_req),
  .cpu_halt(cpu_halt));

/* atp_consts.svh */
// register offsets, field positions and reset values of the timer clocking block
`ifndef ATP_CONSTS_SVH
`define ATP_CONSTS_SVH
`define ATP_OFS_CTRL_A     8'hb0
`define ATP_OFS_CTRL_B     8'hb1
`define ATP_OFS_COUNT      8'hb2
`define ATP_OFS_CMP_A      8'hb3
`define ATP_OFS_CMP_B      8'hb4
`define ATP_OFS_STATUS     8'hb6
`define ATP_OFS_IRQ_EN     8'h70
`define ATP_OFS_FLAGS      8'h37
`define ATP_OFS_GENERAL    8'h43
`define ATP_CTRL_A_RD_MASK 8'hf3
`define ATP_RST_BYTE       8'h00
`define ATP_CTC_MODE       2'h2
`define ATP_BIT_ASYNC_SEL  5
`define ATP_BIT_PSR        1
`define ATP_FLAG_SYNC_LEN  3
`define ATP_WAKE_HALT      3'h4
`endif

/* atp_osc_model.sv */
// crystal oscillator model on the timer clock pin
`timescale 1ns/1ps
module atp_osc_model #(
  parameter int HALF_NS = 203
) (
  input  wire logic en,
  output logic      osc
);
  initial osc = 1'b0;
  // stands still low while off; far slower than mclk, phase unrelated
  always begin
    #(HALF_NS);
    osc = en ? ~osc : 1'b0;
  end
endmodule : atp_osc_model

/* atp_pkg.sv */
// types of the timer clocking block
package atp_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } atp_bus_s;
  typedef enum logic [2:0] {
    ATP_STOP   = 3'h0,
    ATP_DIV1   = 3'h1,
    ATP_DIV8   = 3'h2,
    ATP_DIV32  = 3'h3,
    ATP_DIV64  = 3'h4,
    ATP_DIV128 = 3'h5,
    ATP_DIV256 = 3'h6,
    ATP_DIV1K  = 3'h7
  } atp_presc_e;
  typedef enum logic [2:0] {
    ATP_R_CTRL_A = 3'h0,
    ATP_R_CTRL_B = 3'h1,
    ATP_R_COUNT  = 3'h2,
    ATP_R_CMP_A  = 3'h3,
    ATP_R_CMP_B  = 3'h4
  } atp_reg_e;
endpackage : atp_pkg

/* atp_timer_clocking.sv */
// clock selection, prescaler and oscillator-domain crossing of the 8-bit timer
// How it works
// RQ1 - writes buffered, copied after two oscillator edges
// RQ2 - five registers, five separate buffers
// RQ3 - software waits for busy before rewriting
// RQ4 - busy sets on write, clears on copy
// RQ5 - compare match off while compare/count pending
// RQ6 - core clock over four times oscillator
// RQ7 - software follows safe clock switch order
// RQ8 - count read through copy refreshed per edge
// RQ9 - software reads count after busy clears
// RQ10 - flag crossing: one timer cycle plus three
// RQ11 - compare pin changes on timer tick only
// RQ12 - wake on next timer tick, four halted
// RQ13 - I/O clock default; async detaches pins
// RQ14 - sync counting uses single-cycle enable pulse
// RQ15 - prescaler taps 1,8,32,64,128,256,1024,stop
// RQ16 - prescaler reset bit clears the prescaler
// RQ17 - oscillator off only in deepest sleeps
// RQ18 - software waits busy before wake sleep
// RQ19 - software lets one oscillator cycle pass
// RQ20 - software waits one second for oscillator
// RQ21 - control a fields 7:6,5:4,3:2,1:0, reset zero
// RQ22 - control a bits 3:2 read zero
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "atp_consts.svh"
module atp_timer_clocking (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire atp_pkg::atp_bus_s bus,
  output logic [7:0]           rdata,
  input  wire logic            osc_input_pin,
  input  wire logic            sleeping,
  input  wire logic            deep_sleep,
  output logic                 osc_run,
  output logic                 osc_pins_detach,
  output logic                 cmp_a_out,
  output logic                 cmp_a_oe,
  output logic                 cmp_b_out,
  output logic                 cmp_b_oe,
  output logic                 wake_req,
  output logic                 cpu_halt
);
  import atp_pkg::*;

  localparam int NREG = 5;

  // oscillator pin synchroniser; the second and third stages feed the edge detect
  logic       osc_s1_ff, osc_s2_ff, osc_s3_ff;
  logic       osc_edge;
  logic       async_sel_ff, nxt_async_sel;
  logic       src_tick;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= osc_input_pin;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end
  assign osc_edge = osc_s2_ff & ~osc_s3_ff;
  assign src_tick = async_sel_ff ? osc_edge : 1'b1;  // [RQ13]
  assign osc_pins_detach = async_sel_ff;             // [RQ13]
  assign osc_run = async_sel_ff & ~deep_sleep;       // [RQ17]

  // bus decode
  logic wr_ctrl_a, wr_ctrl_b, wr_count, wr_cmp_a, wr_cmp_b;
  logic wr_status, wr_irq_en, wr_flags, psr_pulse;
  logic [NREG-1:0] reg_wr;
  assign wr_ctrl_a = bus.wr & (bus.addr == `ATP_OFS_CTRL_A);
  assign wr_ctrl_b = bus.wr & (bus.addr == `ATP_OFS_CTRL_B);
  assign wr_count  = bus.wr & (bus.addr == `ATP_OFS_COUNT);
  assign wr_cmp_a  = bus.wr & (bus.addr == `ATP_OFS_CMP_A);
  assign wr_cmp_b  = bus.wr & (bus.addr == `ATP_OFS_CMP_B);
  assign wr_status = bus.wr & (bus.addr == `ATP_OFS_STATUS);
  assign wr_irq_en = bus.wr & (bus.addr == `ATP_OFS_IRQ_EN);
  assign wr_flags  = bus.wr & (bus.addr == `ATP_OFS_FLAGS);
  assign psr_pulse = bus.wr & (bus.addr == `ATP_OFS_GENERAL) & bus.wdata[`ATP_BIT_PSR];
  assign reg_wr = {wr_cmp_b, wr_cmp_a, wr_count, wr_ctrl_b, wr_ctrl_a};

  // per-register temporary buffers and update-busy flags
  logic [7:0]      buf_ff [NREG];
  logic [7:0]      nxt_buf [NREG];
  logic [7:0]      dst_ff [NREG];
  logic [7:0]      nxt_dst [NREG];
  logic [1:0]      edg_ff [NREG];
  logic [1:0]      nxt_edg [NREG];
  logic [NREG-1:0] busy_ff, nxt_busy, xfer;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_buf
      // sync mode copies on the next cycle; async waits for the second edge
      assign xfer[gi] = busy_ff[gi] & ~reg_wr[gi] &
                        (~async_sel_ff | (osc_edge & (edg_ff[gi] == 2'h1)));  // [RQ1]
      always_comb begin
        nxt_buf[gi]  = buf_ff[gi];
        nxt_busy[gi] = busy_ff[gi];
        nxt_edg[gi]  = edg_ff[gi];
        nxt_dst[gi]  = dst_ff[gi];
        if (reg_wr[gi]) begin
          // a new write restarts the transfer; set wins over the clear
          nxt_buf[gi]  = bus.wdata;  // [RQ2]
          nxt_busy[gi] = 1'b1;       // [RQ4]
          nxt_edg[gi]  = 2'h0;
        end else if (xfer[gi]) begin
          nxt_dst[gi]  = buf_ff[gi];  // [RQ1]
          nxt_busy[gi] = 1'b0;        // [RQ4]
          nxt_edg[gi]  = 2'h0;
        end else if (busy_ff[gi] & osc_edge) begin
          nxt_edg[gi]  = edg_ff[gi] + 2'h1;
        end
      end
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          buf_ff[gi]  <= `ATP_RST_BYTE;
          dst_ff[gi]  <= `ATP_RST_BYTE;
          edg_ff[gi]  <= 2'h0;
          busy_ff[gi] <= 1'b0;
        end else begin
          buf_ff[gi]  <= nxt_buf[gi];
          dst_ff[gi]  <= nxt_dst[gi];
          edg_ff[gi]  <= nxt_edg[gi];
          busy_ff[gi] <= nxt_busy[gi];
        end
      end
    end
  endgenerate

  logic [7:0] ctrl_a, ctrl_b, cmp_a, cmp_b;
  atp_presc_e presc_sel;
  assign ctrl_a = dst_ff[ATP_R_CTRL_A] & `ATP_CTRL_A_RD_MASK;  // [RQ22]
  assign ctrl_b = dst_ff[ATP_R_CTRL_B];
  assign cmp_a  = dst_ff[ATP_R_CMP_A];
  assign cmp_b  = dst_ff[ATP_R_CMP_B];
  assign presc_sel = atp_presc_e'(ctrl_b[2:0]);

  // prescaler and tap selection
  logic [9:0] presc_ff, nxt_presc;
  logic       tap_hit, tick_en;
  always_comb begin
    nxt_presc = presc_ff;
    if (psr_pulse) begin
      nxt_presc = 10'h000;  // [RQ16]
    end else if (src_tick) begin
      nxt_presc = presc_ff + 10'h001;
    end
  end
  always_comb begin
    unique case (presc_sel)  // [RQ15]
      ATP_STOP:   tap_hit = 1'b0;
      ATP_DIV1:   tap_hit = 1'b1;
      ATP_DIV8:   tap_hit = &presc_ff[2:0];
      ATP_DIV32:  tap_hit = &presc_ff[4:0];
      ATP_DIV64:  tap_hit = &presc_ff[5:0];
      ATP_DIV128: tap_hit = &presc_ff[6:0];
      ATP_DIV256: tap_hit = &presc_ff[7:0];
      ATP_DIV1K:  tap_hit = &presc_ff[9:0];
    endcase
  end
  // counter steps on a one-cycle enable, never on a derived clock
  assign tick_en = src_tick & tap_hit & ~psr_pulse;  // [RQ14]

  // counter, compare and compare pins
  logic [7:0] cnt_ff, nxt_cnt, cnt_rd_ff, nxt_cnt_rd;
  logic       match_a, match_b, ctc;
  logic       cmp_a_out_ff, nxt_cmp_a_out, cmp_b_out_ff, nxt_cmp_b_out;
  logic [2:0] ev;
  assign ctc = ctrl_a[1:0] == `ATP_CTC_MODE;
  assign match_a = (cnt_ff == cmp_a) & ~busy_ff[ATP_R_CMP_A] & ~busy_ff[ATP_R_COUNT];  // [RQ5]
  assign match_b = (cnt_ff == cmp_b) & ~busy_ff[ATP_R_CMP_B] & ~busy_ff[ATP_R_COUNT];  // [RQ5]
  assign ev = {tick_en & match_b, tick_en & match_a, tick_en & ~ctc & (cnt_ff == 8'hff)};

  function automatic logic pin_next(input logic [1:0] mode, input logic cur);
    case (mode)
      2'h1:    pin_next = ~cur;
      2'h2:    pin_next = 1'b0;
      2'h3:    pin_next = 1'b1;
      default: pin_next = cur;
    endcase
  endfunction : pin_next

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_cmp_a_out = cmp_a_out_ff;
    nxt_cmp_b_out = cmp_b_out_ff;
    if (tick_en) begin
      nxt_cnt = (ctc & match_a) ? 8'h00 : cnt_ff + 8'h01;
      // pins follow the timer tick, not the core clock  [RQ11]
      if (match_a) nxt_cmp_a_out = pin_next(ctrl_a[7:6], cmp_a_out_ff);  // [RQ21]
      if (match_b) nxt_cmp_b_out = pin_next(ctrl_a[5:4], cmp_b_out_ff);  // [RQ21]
    end
    if (xfer[ATP_R_COUNT]) nxt_cnt = buf_ff[ATP_R_COUNT];  // [RQ1]
    // software sees a copy taken only on oscillator edges when async
    nxt_cnt_rd = (~async_sel_ff | osc_edge) ? nxt_cnt : cnt_rd_ff;  // [RQ8]
  end

  // interrupt flags: in async mode one timer cycle wait, then three core cycles; in sync mode set at once
  logic [2:0] pend_ff, nxt_pend;
  logic [2:0] sd_ff [`ATP_FLAG_SYNC_LEN];
  logic [2:0] nxt_sd [`ATP_FLAG_SYNC_LEN];
  logic [2:0] flags_ff, nxt_flags, irq_en_ff, nxt_irq_en, set_ev;
  always_comb begin
    nxt_pend = pend_ff | ev;
    nxt_sd[0] = 3'h0;
    if (async_sel_ff & osc_edge) begin
      nxt_sd[0] = pend_ff;  // [RQ10]
      nxt_pend  = ev;
    end
    for (int k = 1; k < `ATP_FLAG_SYNC_LEN; k++) nxt_sd[k] = sd_ff[k-1];
    if (~async_sel_ff) nxt_pend = 3'h0;
    set_ev = async_sel_ff ? sd_ff[`ATP_FLAG_SYNC_LEN-1] : ev;  // [RQ10]
    nxt_flags = flags_ff;
    if (wr_flags) nxt_flags = flags_ff & ~bus.wdata[2:0];
    nxt_flags = nxt_flags | set_ev;
    nxt_irq_en = wr_irq_en ? bus.wdata[2:0] : irq_en_ff;
  end

  // wake-up pulse and four-cycle halt
  logic       wake_ff, nxt_wake;
  logic [2:0] halt_ff, nxt_halt;
  always_comb begin
    // set_ev in async mode already lags the event by a timer cycle
    nxt_wake = sleeping & |(set_ev & irq_en_ff);  // [RQ12]
    nxt_halt = halt_ff;
    if (wake_ff) begin
      nxt_halt = `ATP_WAKE_HALT;  // [RQ12]
    end else if (halt_ff != 3'h0) begin
      nxt_halt = halt_ff - 3'h1;
    end
  end
  assign wake_req = wake_ff;
  assign cpu_halt = halt_ff != 3'h0;

  always_comb begin
    nxt_async_sel = async_sel_ff;
    if (wr_status) nxt_async_sel = bus.wdata[`ATP_BIT_ASYNC_SEL];
  end

  // read data, valid the cycle after the strobe
  logic [7:0] rdata_ff, nxt_rdata;
  always_comb begin
    nxt_rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `ATP_OFS_CTRL_A:  nxt_rdata = ctrl_a;  // [RQ21]
        `ATP_OFS_CTRL_B:  nxt_rdata = ctrl_b;
        `ATP_OFS_COUNT:   nxt_rdata = cnt_rd_ff;  // [RQ8]
        `ATP_OFS_CMP_A:   nxt_rdata = cmp_a;
        `ATP_OFS_CMP_B:   nxt_rdata = cmp_b;
        `ATP_OFS_STATUS:  nxt_rdata = {2'h0, async_sel_ff, busy_ff[ATP_R_COUNT],
                                       busy_ff[ATP_R_CMP_A], busy_ff[ATP_R_CMP_B],
                                       busy_ff[ATP_R_CTRL_A], busy_ff[ATP_R_CTRL_B]};
        `ATP_OFS_IRQ_EN:  nxt_rdata = {5'h00, irq_en_ff};
        `ATP_OFS_FLAGS:   nxt_rdata = {5'h00, flags_ff};
        default:          nxt_rdata = 8'h00;
      endcase
    end
  end
  assign rdata = rdata_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      async_sel_ff <= 1'b0;  // [RQ13]
      presc_ff     <= 10'h000;
      cnt_ff       <= `ATP_RST_BYTE;
      cnt_rd_ff    <= `ATP_RST_BYTE;
      cmp_a_out_ff <= 1'b0;
      cmp_b_out_ff <= 1'b0;
      pend_ff      <= 3'h0;
      for (int k = 0; k < `ATP_FLAG_SYNC_LEN; k++) sd_ff[k] <= 3'h0;
      flags_ff     <= 3'h0;
      irq_en_ff    <= 3'h0;
      wake_ff      <= 1'b0;
      halt_ff      <= 3'h0;
      rdata_ff     <= 8'h00;
    end else begin
      async_sel_ff <= nxt_async_sel;
      presc_ff     <= nxt_presc;
      cnt_ff       <= nxt_cnt;
      cnt_rd_ff    <= nxt_cnt_rd;
      cmp_a_out_ff <= nxt_cmp_a_out;
      cmp_b_out_ff <= nxt_cmp_b_out;
      pend_ff      <= nxt_pend;
      for (int k = 0; k < `ATP_FLAG_SYNC_LEN; k++) sd_ff[k] <= nxt_sd[k];
      flags_ff     <= nxt_flags;
      irq_en_ff    <= nxt_irq_en;
      wake_ff      <= nxt_wake;
      halt_ff      <= nxt_halt;
      rdata_ff     <= nxt_rdata;
    end
  end

  assign cmp_a_out = cmp_a_out_ff;
  assign cmp_a_oe  = ctrl_a[7:6] != 2'h0;
  assign cmp_b_out = cmp_b_out_ff;
  assign cmp_b_oe  = ctrl_a[5:4] != 2'h0;
endmodule : atp_timer_clocking

/* tb_atp.sv */
// self-checking bench of the timer clocking block
`timescale 1ns/1ps
`include "atp_consts.svh"
module tb;
  import atp_pkg::*;
  logic       mclk, rst, osc, sleeping, deep_sleep, osc_run, detach;
  logic       a_out, a_oe, b_out, b_oe, wake_req, cpu_halt;
  logic [7:0] rdata, v, w;
  atp_bus_s   bus;
  int         miscompares, n_tests, cyc, n_osc, n_tog, e0, k, t;
  int         dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] ofs[7] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb6, 8'hb5};
  atp_timer_clocking DUT (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
    .osc_input_pin(osc), .sleeping(sleeping), .deep_sleep(deep_sleep), .osc_run(osc_run),
    .osc_pins_detach(detach), .cmp_a_out(a_out), .cmp_a_oe(a_oe), .cmp_b_out(b_out),
    .cmp_b_oe(b_oe), .wake_req(wake_req), .cpu_halt(cpu_halt));
  atp_osc_model u_osc (.en(osc_run), .osc(osc));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge osc) n_osc++;
  always @(a_out) n_tog++;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask : wr
  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd
  task automatic wait_idle(input logic [7:0] m);
    t = 0;
    do begin
      rd(`ATP_OFS_STATUS, v);
      t++;
    end while ((v & m) != 8'h00 && t < 500);
    chk(v & m, 8'h00);
  endtask : wait_idle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    bus = '0;
    rst = 1'b1;
    sleeping = 1'b0;
    deep_sleep = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    foreach (ofs[i]) begin
      rd(ofs[i], v);
      chk(v, `ATP_RST_BYTE);
    end
    wr(`ATP_OFS_CTRL_A, 8'hff);
    rd(`ATP_OFS_CTRL_A, v);
    chk(v, `ATP_CTRL_A_RD_MASK);
    wr(`ATP_OFS_CTRL_A, 8'h00);
    for (k = 0; k < 8; k++) begin
      wr(`ATP_OFS_CTRL_B, 8'h00);
      wr(`ATP_OFS_COUNT, 8'h00);
      wr(`ATP_OFS_GENERAL, 8'h02);
      wr(`ATP_OFS_CTRL_B, 8'(k));
      repeat (8 * (k == 0 ? 8 : dv[k])) @(posedge mclk);
      rd(`ATP_OFS_COUNT, v);
      chk({7'h0, k == 0 ? v == 8'h00 : v >= 8'h06 && v <= 8'h0a}, 8'h01);
    end
    // a toggles and clears on compare a, b sets: one a toggle every four ticks
    wr(`ATP_OFS_CTRL_A, 8'h72);
    wr(`ATP_OFS_CMP_A, 8'h03);
    wr(`ATP_OFS_CMP_B, 8'h01);
    // start below the compare value, else the first match waits for a wrap
    wr(`ATP_OFS_COUNT, 8'h00);
    wr(`ATP_OFS_CTRL_B, 8'h01);
    repeat (10) @(posedge mclk);
    e0 = n_tog;
    repeat (80) @(posedge mclk);
    chk({7'h0, n_tog - e0 >= 19 && n_tog - e0 <= 21}, 8'h01);
    chk({7'h0, b_out}, 8'h01);
    wr(`ATP_OFS_CTRL_A, 8'h62);
    repeat (10) @(posedge mclk);
    chk({7'h0, b_out}, 8'h00);
    chk({6'h0, a_oe, b_oe}, 8'h03);
    wr(`ATP_OFS_CTRL_B, 8'h00);
    wr(`ATP_OFS_IRQ_EN, 8'h00);
    wr(`ATP_OFS_STATUS, 8'h20);
    #1 chk({6'h0, detach, osc_run}, 8'h03);
    wr(`ATP_OFS_COUNT, 8'h00);
    wr(`ATP_OFS_CMP_A, 8'h05);
    wr(`ATP_OFS_CTRL_A, {6'h0, `ATP_CTC_MODE});
    wr(`ATP_OFS_CTRL_B, 8'h01);
    wr(`ATP_OFS_CMP_B, 8'h33);
    e0 = n_osc;
    rd(`ATP_OFS_STATUS, v);
    chk(v & 8'h04, 8'h04);
    wait_idle(8'h1f);
    chk({7'h0, n_osc - e0 >= 1 && n_osc - e0 <= 3}, 8'h01);
    rd(`ATP_OFS_CMP_B, v);
    chk(v, 8'h33);
    rd(`ATP_OFS_CMP_A, v);
    chk(v, 8'h05);
    rd(`ATP_OFS_COUNT, v);
    // three or four ticks apart, never a whole six-tick lap
    repeat (60) @(posedge mclk);
    rd(`ATP_OFS_COUNT, w);
    chk({7'h0, v !== w}, 8'h01);
    wr(`ATP_OFS_FLAGS, 8'h07);
    wr(`ATP_OFS_IRQ_EN, 8'h02);
    sleeping <= 1'b1;
    t = 0;
    while (wake_req !== 1'b1 && t < 2000) begin
      @(negedge mclk);
      t++;
    end
    chk({7'h0, wake_req}, 8'h01);
    t = 0;
    repeat (8) @(negedge mclk) t += int'(cpu_halt === 1'b1);
    chk(8'(t), {5'h0, `ATP_WAKE_HALT});
    rd(`ATP_OFS_FLAGS, v);
    chk(v, 8'h02);
    wr(`ATP_OFS_CMP_B, 8'h33);
    wait_idle(8'h04);
    @(posedge mclk);
    sleeping <= 1'b0;
    deep_sleep <= 1'b1;
    @(posedge mclk);
    #1 chk({7'h0, osc_run}, 8'h00);
    report_and_stop();
  end
endmodule : tb
